// *** design/ica_defines.svh ***
// Register offsets, field positions, reset values and the clock rate limit for the address/status block.
`ifndef ICA_DEFINES_SVH
`define ICA_DEFINES_SVH
`define ICA_OFS_CLK_RATE 8'h08
`define ICA_OFS_OWN_LOW 8'h0C
`define ICA_OFS_OWN_HIGH 8'h10
`define ICA_OFS_BYTE_BUF 8'h18
`define ICA_OFS_STATUS_ONE 8'h1C
`define ICA_OFS_STATUS_THREE 8'h24
`define ICA_OFS_CTRL 8'h40
`define ICA_OFS_IRQ_EN 8'h44
`define ICA_OFS_IRQ_CLR 8'h48
`define ICA_BIT_START_SENT 0
`define ICA_BIT_STATION_MATCH 1
`define ICA_BIT_CFG_LATCH 6
`define ICA_BIT_ID_WIDTH 7
`define ICA_RST_CLK_RATE 6'h00
`define ICA_RST_OWN_HIGH 8'h00
`define ICA_RST_BYTE 8'h00
`define ICA_MHZ_MAX 6'h30
`endif

// *** design/ica_pkg.sv ***
// Types shared by the address/status block.
package ica_pkg;
   typedef struct packed {
      logic start_sent;
      logic addr_done;
      logic addr_match;
      logic [7:0] rx_byte;
      logic rx_valid;
   } ica_evt_t;
   typedef struct packed {
      logic [9:0] own_addr;
      logic ten_bit;
      logic [5:0] clk_mhz;
      logic clk_ok;
   } ica_cfg_t;
endpackage

// *** design/ica_regs.sv ***
// Clock rate, own-address, byte buffer and first status flags of a two-wire bus controller.
`timescale 1ns/1ns
`include "ica_defines.svh"
// Overview of operation
// - The 6-bit clock rate field gives the module clock in MHz, codes 1 to 48 are valid and others disable.
// - Own-address bit zero is taken from the low register bit zero only in 10-bit mode.
// - Low register bits seven to one hold own-address bits six to zero in 7-bit mode and bits seven to one in 10-bit mode.
// - High register bits two and one give own-address bits nine and eight only in 10-bit mode.
// - High register bit seven selects 7-bit (zero) or 10-bit (one) addressing.
// - The byte buffer takes the next byte to send and presents the received byte.
// - The start-sent flag sets on a sent start and clears on status read then buffer write or disable.
// - The station match flag sets on address match or sent, and clears on status one then status three read or disable.
module ica_regs
   import ica_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic link_clk_in,
   input wire ica_evt_t evt_in,
   output logic [31:0] rdata_out,
   output logic irq_out,
   output ica_cfg_t cfg_out,
   output logic [7:0] tx_byte_out,
   output logic tx_load_out,
   output logic module_on_out,
   output logic link_edge_out
);
   logic [5:0] clock_mhz_setting_r;
   logic [7:0] own_station_low_r;
   logic [7:0] own_station_high_r;
   logic [7:0] byte_buffer_r;
   logic module_on_r;
   logic start_sent_flag_r;
   logic station_match_flag_r;
   logic status_one_read_r;
   logic [1:0] irq_en_r;
   logic [31:0] rdata_r;
   logic irq_r;
   logic tx_load_r;
   logic [2:0] lclk_sync_r;
   logic lclk_state_r;
   logic link_edge_r;
   ica_cfg_t cfg_r;

   // Exact byte address match with no aliasing, so unmapped offsets read as zero.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   wire wr_clk = wr_in && hit(addr_in, `ICA_OFS_CLK_RATE);
   wire wr_low = wr_in && hit(addr_in, `ICA_OFS_OWN_LOW);
   wire wr_high = wr_in && hit(addr_in, `ICA_OFS_OWN_HIGH);
   wire wr_buf = wr_in && hit(addr_in, `ICA_OFS_BYTE_BUF);
   wire wr_ctrl = wr_in && hit(addr_in, `ICA_OFS_CTRL);
   wire wr_ien = wr_in && hit(addr_in, `ICA_OFS_IRQ_EN);
   wire wr_iclr = wr_in && hit(addr_in, `ICA_OFS_IRQ_CLR);
   wire rd_status_one = rd_in && hit(addr_in, `ICA_OFS_STATUS_ONE);
   wire rd_status_three = rd_in && hit(addr_in, `ICA_OFS_STATUS_THREE);

   wire clk_ok = (clock_mhz_setting_r != 6'h00) && (clock_mhz_setting_r <= `ICA_MHZ_MAX);
   wire ten_bit = own_station_high_r[`ICA_BIT_ID_WIDTH];
   wire [9:0] own_addr = ten_bit ? {own_station_high_r[2:1], own_station_low_r}
                                 : {3'h0, own_station_low_r[7:1]};

   // Unrelated accesses between the status read and the clearing access keep the sequence open.
   // start flag clear
   wire clr_start = status_one_read_r && wr_buf;
   wire clr_match = status_one_read_r && rd_status_three;
   wire start_nxt = evt_in.start_sent || (module_on_r && start_sent_flag_r && !clr_start);
   wire match_nxt = evt_in.addr_done || evt_in.addr_match ||
                    (module_on_r && station_match_flag_r && !clr_match);
   wire set_start = module_on_r && start_nxt;
   wire set_match = module_on_r && match_nxt;

   wire [1:0] sts_bits = {station_match_flag_r, start_sent_flag_r};
   wire [31:0] rd_mux =
      hit(addr_in, `ICA_OFS_CLK_RATE) ? {26'h0, clock_mhz_setting_r} :
      hit(addr_in, `ICA_OFS_OWN_LOW) ? {24'h0, own_station_low_r} :
      hit(addr_in, `ICA_OFS_OWN_HIGH) ? {24'h0, own_station_high_r} :
      hit(addr_in, `ICA_OFS_BYTE_BUF) ? {24'h0, byte_buffer_r} :
      hit(addr_in, `ICA_OFS_STATUS_ONE) ? {30'h0, sts_bits} :
      hit(addr_in, `ICA_OFS_CTRL) ? {31'h0, module_on_r} :
      hit(addr_in, `ICA_OFS_IRQ_EN) ? {30'h0, irq_en_r} : 32'h0;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         clock_mhz_setting_r <= `ICA_RST_CLK_RATE;
      end else if (wr_clk) begin
         clock_mhz_setting_r <= wdata_in[5:0];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         own_station_low_r <= 8'h00;
         own_station_high_r <= `ICA_RST_OWN_HIGH;
      end else begin
         if (wr_low) begin
            own_station_low_r <= wdata_in[7:0];
         end
         if (wr_high) begin
            own_station_high_r <= wdata_in[7:0] & 8'hC6;
         end
      end
   end

   // A software write wins over a received byte in the same cycle; that received byte is lost.
   // byte buffer
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         byte_buffer_r <= `ICA_RST_BYTE;
      end else if (wr_buf) begin
         byte_buffer_r <= wdata_in[7:0];
      end else if (evt_in.rx_valid) begin
         byte_buffer_r <= evt_in.rx_byte;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         module_on_r <= 1'b0;
         irq_en_r <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            module_on_r <= wdata_in[0];
         end
         if (wr_ien) begin
            irq_en_r <= wdata_in[1:0];
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         start_sent_flag_r <= 1'b0;
         station_match_flag_r <= 1'b0;
      end else begin
         start_sent_flag_r <= set_start && !(wr_iclr && wdata_in[0] && !evt_in.start_sent);
         station_match_flag_r <= set_match &&
            !(wr_iclr && wdata_in[1] && !(evt_in.addr_done || evt_in.addr_match));
      end
   end

   // A status one read opens both clear sequences until the access that completes one ends it.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         status_one_read_r <= 1'b0;
      end else if (rd_status_one) begin
         status_one_read_r <= 1'b1;
      end else if (wr_buf || rd_status_three || !module_on_r) begin
         status_one_read_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         rdata_r <= 32'h0;
         irq_r <= 1'b0;
         tx_load_r <= 1'b0;
         cfg_r <= '0;
      end else begin
         // Read data is zero outside its answer cycle, so a stale word never looks valid.
         rdata_r <= rd_in ? rd_mux : 32'h0;
         // Registering the level costs a cycle of lag but keeps the pin free of glitches.
         irq_r <= |(sts_bits & irq_en_r);
         tx_load_r <= wr_buf;
         // The configuration lags a register write by one cycle.
         cfg_r <= '{own_addr: own_addr, ten_bit: ten_bit,
                    clk_mhz: clock_mhz_setting_r, clk_ok: clk_ok};
      end
   end

   // Three stages on the link clock; the first stage feeds only the second.
   // The bus clock idles high, so the filter starts high and reset gives no false edge.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         lclk_sync_r <= 3'h7;
         lclk_state_r <= 1'b1;
         link_edge_r <= 1'b0;
      end else begin
         lclk_sync_r <= {lclk_sync_r[1:0], link_clk_in};
         link_edge_r <= 1'b0;
         if ((lclk_sync_r[1] == lclk_sync_r[2]) && (lclk_sync_r[2] != lclk_state_r)) begin
            lclk_state_r <= lclk_sync_r[2];
            link_edge_r <= lclk_sync_r[2];
         end
      end
   end

   assign rdata_out = rdata_r;
   assign irq_out = irq_r;
   assign cfg_out = cfg_r;
   assign tx_byte_out = byte_buffer_r;
   assign tx_load_out = tx_load_r;
   assign module_on_out = module_on_r;
   assign link_edge_out = link_edge_r;

   // Assertion checks.
   start_clear_seq_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (status_one_read_r && wr_buf && !evt_in.start_sent && !wr_iclr) |=> !start_sent_flag_r)
      else $error("start flag not cleared by status read then buffer write");
   start_set_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (module_on_r && evt_in.start_sent) |=> start_sent_flag_r)
      else $error("start flag not set");
   match_clear_seq_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (status_one_read_r && rd_status_three && !evt_in.addr_done && !evt_in.addr_match && !wr_iclr)
      |=> !station_match_flag_r)
      else $error("match flag not cleared by status reads");
   match_set_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (module_on_r && (evt_in.addr_done || evt_in.addr_match)) |=> station_match_flag_r)
      else $error("match flag not set");
   disable_clear_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      !module_on_r |=> !start_sent_flag_r && !station_match_flag_r)
      else $error("flags survive disable");
   rate_decode_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      ##1 cfg_out.clk_ok == ($past(clock_mhz_setting_r) inside {[6'h01:6'h30]}))
      else $error("rate decode wrong");
   addr_seven_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (!ten_bit ##1 1'b1) |-> cfg_out.own_addr == {3'h0, $past(own_station_low_r[7:1])})
      else $error("7-bit own address wrong");
   addr_ten_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (ten_bit ##1 1'b1) |-> cfg_out.own_addr[9:8] == $past(own_station_high_r[2:1]))
      else $error("10-bit own address wrong");
   reserved_zero_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      rd_in |=> rdata_out[31:8] == 24'h0)
      else $error("reserved bits not zero");
   rx_byte_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (evt_in.rx_valid && !wr_buf) |=> byte_buffer_r == $past(evt_in.rx_byte))
      else $error("received byte not presented");

   // Register writes, read timing, reserved bits and the 10-bit own address low byte.
   rdata_idle_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      !rd_in |=> rdata_out == 32'h0)
      else $error("read data not idle outside its answer cycle");
   buf_write_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      wr_buf |=> byte_buffer_r == $past(wdata_in[7:0]) && tx_load_out)
      else $error("byte buffer write not taken");
   rate_write_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      wr_clk |=> clock_mhz_setting_r == $past(wdata_in[5:0]))
      else $error("rate field write not taken");
   low_keep_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      wr_low |=> own_station_low_r == $past(wdata_in[7:0]))
      else $error("low own address write not taken");
   high_mask_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      wr_high |=> own_station_high_r[7:6] == $past(wdata_in[7:6]) &&
                  own_station_high_r[2:1] == $past(wdata_in[2:1]) &&
                  own_station_high_r[5:3] == 3'h0 && !own_station_high_r[0])
      else $error("high own address reserved bits not masked");
   addr_low_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (ten_bit ##1 1'b1) |-> cfg_out.own_addr[7:0] == $past(own_station_low_r))
      else $error("10-bit own address low byte wrong");

   // Flag holding, status reads, the end of the clear sequence, the module enable write and the interrupt level.
   start_keep_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (module_on_r && start_sent_flag_r && !clr_start && !(wr_iclr && wdata_in[0]))
      |=> start_sent_flag_r)
      else $error("start flag lost without a clear");
   match_keep_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (module_on_r && station_match_flag_r && !clr_match && !(wr_iclr && wdata_in[1]))
      |=> station_match_flag_r)
      else $error("match flag lost without a clear");
   status_read_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      rd_status_one |=> rdata_out == {30'h0, $past(station_match_flag_r), $past(start_sent_flag_r)})
      else $error("status one read wrong");
   arm_drop_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (status_one_read_r && !rd_status_one && (wr_buf || rd_status_three)) |=> !status_one_read_r)
      else $error("clear sequence left open after completion");
   enable_write_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      wr_ctrl |=> module_on_out == $past(wdata_in[0]))
      else $error("module enable write not taken");
   start_irq_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (start_sent_flag_r && irq_en_r[0]) |=> irq_out)
      else $error("start flag interrupt missing");
   match_irq_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (station_match_flag_r && irq_en_r[1]) |=> irq_out)
      else $error("match flag interrupt missing");
   irq_quiet_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      ((sts_bits & irq_en_r) == 2'h0) |=> !irq_out)
      else $error("interrupt without an enabled flag");
   cov_start_c: cover property (@(posedge clk_sys_in) start_sent_flag_r ##1 !start_sent_flag_r);
   cov_match_c: cover property (@(posedge clk_sys_in) clr_match && station_match_flag_r);
   cov_irq_c: cover property (@(posedge clk_sys_in) irq_out);
   cov_edge_c: cover property (@(posedge clk_sys_in) link_edge_out);
   cov_ten_c: cover property (@(posedge clk_sys_in) cfg_out.ten_bit);
endmodule // ica_regs

// *** bench/ica_far_model.sv ***
// Remote bus party: event pulses, received bytes and the link clock.
`timescale 1ns/1ns
module ica_far_model
   import ica_pkg::*;
(
   input wire logic clk_sys_in,
   output ica_evt_t evt_out,
   output logic link_clk_out
);
   initial begin
      evt_out = '0;
      link_clk_out = 1'b1;
   end
   task automatic send(input logic [2:0] k, input logic [7:0] b, input logic v);
      @(posedge clk_sys_in);
      evt_out <= '{start_sent: k[2], addr_done: k[1], addr_match: k[0], rx_byte: b, rx_valid: v};
      @(posedge clk_sys_in);
      // The byte lines are inverted once released so no stale value looks valid.
      evt_out <= '{rx_byte: ~b, default: 1'b0};
   endtask
   // The link clock idles high between frames and is offset from the system clock.
   task automatic frame(input int n);
      #7;
      repeat (n) begin
         #80 link_clk_out = 1'b0;
         #80 link_clk_out = 1'b1;
      end
   endtask
endmodule // ica_far_model

// *** bench/ica_regs_tb.sv ***
// Bench for the clock rate, own-address, byte buffer and status block.
`timescale 1ns/1ns
`include "ica_defines.svh"
module ica_regs_tb;
   import ica_pkg::*;
   localparam logic [7:0] ST = `ICA_OFS_STATUS_ONE;
   localparam logic [7:0] BB = `ICA_OFS_BYTE_BUF;
   localparam logic [7:0] S3 = `ICA_OFS_STATUS_THREE;
   localparam logic [7:0] CT = `ICA_OFS_CTRL;
   localparam logic [7:0] OH = `ICA_OFS_OWN_HIGH;
   localparam logic [7:0] EN = `ICA_OFS_IRQ_EN;
   logic clk_sys_in, sys_rst_in, wr_in, rd_in, link_clk;
   logic irq_out, tx_load_out, module_on_out, link_edge_out;
   logic [7:0] addr_in, tx_byte_out;
   logic [31:0] wdata_in, rdata_out;
   ica_evt_t evt;
   ica_cfg_t cfg_out;
   int bad_count = 0;
   int checks_done = 0;
   int edges = 0;
   logic [5:0] codes [7] = '{6'h00, 6'h01, 6'h02, 6'h18, 6'h30, 6'h31, 6'h3F};
   ica_regs uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .link_clk_in(link_clk),
      .evt_in(evt), .rdata_out(rdata_out), .irq_out(irq_out), .cfg_out(cfg_out),
      .tx_byte_out(tx_byte_out), .tx_load_out(tx_load_out),
      .module_on_out(module_on_out), .link_edge_out(link_edge_out));
   ica_far_model far (.clk_sys_in(clk_sys_in), .evt_out(evt), .link_clk_out(link_clk));
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      if (link_edge_out === 1'b1) edges++;
   end
   task automatic conclude;
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask
   // Read data is looked at only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      @(negedge clk_sys_in);
      chk("rdata", e, rdata_out);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      bad_count++;
      conclude();
   end
   initial begin
      sys_rst_in = 1'b1;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 8'h00;
      wdata_in = 32'h0;
      repeat (4) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      rd(`ICA_OFS_CLK_RATE, 32'h0);
      rd(OH, 32'h0);
      rd(BB, 32'h0);
      rd(ST, 32'h0);
      rd(8'h3C, 32'h0);
      foreach (codes[i]) begin
         wr(`ICA_OFS_CLK_RATE, {26'h3FFFFFF, codes[i]});
         rd(`ICA_OFS_CLK_RATE, {26'h0, codes[i]});
         chk("clk_mhz", {26'h0, codes[i]}, {26'h0, cfg_out.clk_mhz});
         chk("clk_ok", {31'h0, codes[i] != 6'h00 && codes[i] <= 6'h30}, {31'h0, cfg_out.clk_ok});
      end
      wr(`ICA_OFS_CLK_RATE, 32'h8);
      wr(`ICA_OFS_OWN_LOW, 32'hFFFFFFA5);
      wr(OH, 32'hFFFFFFFD);
      rd(`ICA_OFS_OWN_LOW, 32'hA5);
      rd(OH, 32'hC4);
      chk("own_addr", 32'h2A5, {22'h0, cfg_out.own_addr});
      chk("ten_bit", 32'h1, {31'h0, cfg_out.ten_bit});
      wr(OH, 32'h46);
      cyc(2);
      chk("own_addr", 32'h52, {22'h0, cfg_out.own_addr});
      chk("ten_bit", 32'h0, {31'h0, cfg_out.ten_bit});
      far.send(3'b110, 8'h00, 1'b0);
      rd(ST, 32'h0);
      wr(CT, 32'h1);
      wr(BB, 32'hFFFFFF5A);
      cyc(1);
      chk("module_on", 32'h1, {31'h0, module_on_out});
      chk("tx_load", 32'h1, {31'h0, tx_load_out});
      chk("tx_byte", 32'h5A, {24'h0, tx_byte_out});
      rd(BB, 32'h5A);
      far.send(3'b000, 8'hC3, 1'b1);
      rd(BB, 32'hC3);
      far.send(3'b100, 8'h00, 1'b0);
      wr(BB, 32'h11);
      rd(ST, 32'h1);
      wr(BB, 32'h11);
      rd(ST, 32'h0);
      rd(S3, 32'h0);
      far.send(3'b001, 8'h00, 1'b0);
      rd(S3, 32'h0);
      rd(ST, 32'h2);
      rd(S3, 32'h0);
      rd(ST, 32'h0);
      far.send(3'b110, 8'h00, 1'b0);
      rd(ST, 32'h3);
      wr(CT, 32'h0);
      rd(ST, 32'h0);
      chk("module_on", 32'h0, {31'h0, module_on_out});
      wr(CT, 32'h1);
      wr(EN, 32'h3);
      far.send(3'b001, 8'h00, 1'b0);
      cyc(2);
      chk("irq", 32'h1, {31'h0, irq_out});
      wr(EN, 32'h1);
      cyc(2);
      chk("irq", 32'h0, {31'h0, irq_out});
      wr(EN, 32'h2);
      cyc(2);
      chk("irq", 32'h1, {31'h0, irq_out});
      wr(`ICA_OFS_IRQ_CLR, 32'h2);
      cyc(2);
      chk("irq", 32'h0, {31'h0, irq_out});
      rd(ST, 32'h0);
      wr(EN, 32'h1);
      far.send(3'b100, 8'h00, 1'b0);
      cyc(2);
      chk("irq", 32'h1, {31'h0, irq_out});
      wr(`ICA_OFS_IRQ_CLR, 32'h1);
      cyc(2);
      chk("irq", 32'h0, {31'h0, irq_out});
      chk("link_edges", 32'h0, edges);
      edges = 0;
      far.frame(5);
      cyc(6);
      chk("link_edges", 32'h5, edges);
      conclude();
   end
endmodule // ica_regs_tb
